// >>> hdl/dmsep_top.v
// Dual mode serial memory port: transmit-only stream and two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "dmsep_consts.vh"

module dmsep_top #(
   parameter [17:0] WR_CYCLES = `DMSEP_TWR_CYC
) (
   // Clock and reset
   input wire CLOCK_I,
   input wire ARST_N_I,
   // Two-wire bus pins
   input wire SCL_I,
   input wire SDA_I,
   output reg SDA_O,
   output reg SDA_OE_O,
   // Transmit-only clock pin
   input wire TRANSMIT_ONLY_CLOCK_I,
   // Status
   output reg BIDIRECTIONAL_MODE_O,
   output reg BUSY_O
);

   // Bidirectional engine states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX = 3'h1;
   localparam [2:0] ST_ACK = 3'h2;
   localparam [2:0] ST_TX = 3'h3;
   localparam [2:0] ST_RACK = 3'h4;
   localparam [2:0] ST_WAIT = 3'h5;

   localparam [17:0] WR_LAST = WR_CYCLES - 18'h0_0001;

   // Synchronised pins and their previous samples
   wire [2:0] sync_w;
   wire s_scl = sync_w[0];
   wire s_sda = sync_w[1];
   wire s_tck = sync_w[2];
   reg p_scl_q;
   reg p_sda_q;
   reg p_tck_q;

   // Array, page buffer and read port
   reg [7:0] mem [0:(1<<`DMSEP_ADDR_W)-1];
   reg [7:0] pg_buf [0:`DMSEP_PAGE_SZ-1];
   wire [7:0] mem_rd;

   // Control state
   reg [2:0] state_q;
   reg [1:0] phase_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] sh_q;
   reg dir_rd_q;
   reg ack_q;
   reg wr_en_q;
   reg [6:0] addr_q;
   reg [2:0] pg_base_q;
   reg [15:0] pg_vld_q;
   reg [17:0] wr_cnt_q;
   reg [3:0] init_cnt_q;
   reg start_hi_q;
   reg [3:0] tx_bit_q;

   // Bus events
   wire scl_rise;
   wire scl_fall;
   wire tck_rise;
   wire bus_start;
   wire bus_stop;
   wire rx_byte;
   wire data_wr;
   wire prog_go;

   dmsep_sync #(
      .W(3)
   ) u_sync (
      .clk_i(CLOCK_I),
      .arst_n_i(ARST_N_I),
      .async_i({TRANSMIT_ONLY_CLOCK_I, SDA_I, SCL_I}),
      .sync_o(sync_w)
   );

   // Edge history; only second-stage outputs are looked at
   always @(posedge CLOCK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         p_scl_q <= 1'b1;
         p_sda_q <= 1'b1;
         p_tck_q <= 1'b1;
      end
      else
      begin
         p_scl_q <= s_scl;
         p_sda_q <= s_sda;
         p_tck_q <= s_tck;
      end
   end

   // Edges and line conditions
   assign scl_rise = s_scl & ~p_scl_q;
   assign scl_fall = ~s_scl & p_scl_q;
   assign tck_rise = s_tck & ~p_tck_q;
   // SDA moving while SCL stays high is a condition, never data
   assign bus_start = s_scl & p_scl_q & p_sda_q & ~s_sda;
   assign bus_stop = s_scl & p_scl_q & ~p_sda_q & s_sda;

   // A full byte has been shifted in and SCL has fallen
   assign rx_byte = BIDIRECTIONAL_MODE_O & ~BUSY_O & (state_q == ST_RX) &
                    scl_fall & (bit_cnt_q == `DMSEP_BYTE_BITS) &
                    ~bus_start & ~bus_stop;
   assign data_wr = rx_byte & (phase_q == `DMSEP_PH_WDATA);
   // End of the self-timed cycle; pin levels no longer matter
   assign prog_go = BUSY_O & (wr_cnt_q == WR_LAST);
   assign mem_rd = mem[addr_q];

   // Array and page buffer storage, no reset on data
   always @(posedge CLOCK_I)
   begin : store
      integer i;
      if (data_wr)
      begin
         pg_buf[addr_q[3:0]] <= sh_q;
      end
      // All buffered bytes land in one write cycle
      if (prog_go)
      begin
         for (i = 0; i < `DMSEP_PAGE_SZ; i = i + 1)
         begin
            if (pg_vld_q[i])
            begin
               mem[{pg_base_q, i[3:0]}] <= pg_buf[i];
            end
         end
      end
   end

   // Mode, transmit-only stream and bidirectional slave
   always @(posedge CLOCK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         SDA_O <= 1'b0;
         SDA_OE_O <= 1'b0;
         BIDIRECTIONAL_MODE_O <= 1'b0;
         BUSY_O <= 1'b0;
         state_q <= ST_IDLE;
         phase_q <= `DMSEP_PH_SLAVE;
         bit_cnt_q <= 4'h0;
         sh_q <= 8'h00;
         dir_rd_q <= 1'b0;
         ack_q <= 1'b0;
         wr_en_q <= 1'b0;
         addr_q <= `DMSEP_START_LO;
         pg_base_q <= 3'h0;
         pg_vld_q <= 16'h0000;
         wr_cnt_q <= 18'h0_0000;
         init_cnt_q <= 4'h0;
         start_hi_q <= 1'b1;
         tx_bit_q <= 4'h0;
      end
      else if (!BIDIRECTIONAL_MODE_O)
      begin
         // Output only ever pulls low; the enable carries the data
         SDA_O <= 1'b0;
         if (scl_fall)
         begin
            // One-way switch; only reset brings the stream back
            BIDIRECTIONAL_MODE_O <= 1'b1;
            SDA_OE_O <= 1'b0;
         end
         else if (tck_rise)
         begin
            if (init_cnt_q < `DMSEP_INIT_CLKS)
            begin
               // Line is released for all nine setup clocks
               init_cnt_q <= init_cnt_q + 4'h1;
               SDA_OE_O <= 1'b0;
               if (init_cnt_q < `DMSEP_INIT_SAMP)
               begin
                  // Any low sample picks the bottom of the array
                  start_hi_q <= start_hi_q & s_sda;
               end
               else
               begin
                  addr_q <= start_hi_q ? `DMSEP_START_HI :
                            `DMSEP_START_LO;
               end
            end
            else if (tx_bit_q == `DMSEP_BYTE_BITS)
            begin
               // Don't-care ninth bit, then the next byte
               SDA_OE_O <= 1'b0;
               tx_bit_q <= 4'h0;
               addr_q <= addr_q + 7'h01;
            end
            else
            begin
               // Bit index counts down from seven
               SDA_OE_O <= ~mem_rd[~tx_bit_q[2:0]];
               tx_bit_q <= tx_bit_q + 4'h1;
            end
         end
      end
      else if (BUSY_O)
      begin
         // Deaf to the bus while programming, so polls get no ack
         SDA_OE_O <= 1'b0;
         state_q <= ST_IDLE;
         if (prog_go)
         begin
            BUSY_O <= 1'b0;
            wr_cnt_q <= 18'h0_0000;
            pg_vld_q <= 16'h0000;
         end
         else
         begin
            wr_cnt_q <= wr_cnt_q + 18'h0_0001;
         end
      end
      else
      begin
         // Write enable must stay high for the whole transfer
         if (!s_tck && state_q != ST_IDLE)
         begin
            wr_en_q <= 1'b0;
         end
         if (bus_start)
         begin
            // Repeated start drops any unprogrammed page data
            state_q <= ST_RX;
            phase_q <= `DMSEP_PH_SLAVE;
            bit_cnt_q <= 4'h0;
            SDA_OE_O <= 1'b0;
            pg_vld_q <= 16'h0000;
            wr_en_q <= s_tck;
         end
         else if (bus_stop)
         begin
            state_q <= ST_IDLE;
            SDA_OE_O <= 1'b0;
            if ((|pg_vld_q) && wr_en_q && s_tck)
            begin
               BUSY_O <= 1'b1;
               wr_cnt_q <= 18'h0_0000;
            end
            else
            begin
               // Protected or empty write: nothing to program
               pg_vld_q <= 16'h0000;
            end
         end
         else
         begin
            case (state_q)
               ST_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_q <= {sh_q[6:0], s_sda};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
                  else if (rx_byte)
                  begin
                     bit_cnt_q <= 4'h0;
                     if (phase_q == `DMSEP_PH_SLAVE)
                     begin
                        // Three middle bits are don't-care
                        if (sh_q[7:4] == `DMSEP_DEV_CODE)
                        begin
                           SDA_OE_O <= 1'b1;
                           dir_rd_q <= sh_q[0];
                           state_q <= ST_ACK;
                        end
                        else
                        begin
                           state_q <= ST_IDLE;
                        end
                     end
                     else if (phase_q == `DMSEP_PH_WADDR)
                     begin
                        addr_q <= sh_q[6:0];
                        SDA_OE_O <= 1'b1;
                        state_q <= ST_ACK;
                     end
                     else
                     begin
                        // Only the low four bits move inside a page
                        pg_vld_q[addr_q[3:0]] <= 1'b1;
                        pg_base_q <= addr_q[6:4];
                        addr_q <= {addr_q[6:4],
                                   addr_q[3:0] + 4'h1};
                        SDA_OE_O <= 1'b1;
                        state_q <= ST_ACK;
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     if (phase_q == `DMSEP_PH_SLAVE && dir_rd_q)
                     begin
                        // Read starts from the address counter
                        sh_q <= mem_rd;
                        SDA_OE_O <= ~mem_rd[7];
                        bit_cnt_q <= 4'h1;
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        SDA_OE_O <= 1'b0;
                        state_q <= ST_RX;
                        phase_q <= (phase_q == `DMSEP_PH_SLAVE) ?
                                   `DMSEP_PH_WADDR : `DMSEP_PH_WDATA;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt_q == `DMSEP_BYTE_BITS)
                     begin
                        // Release for the master's acknowledge
                        SDA_OE_O <= 1'b0;
                        addr_q <= addr_q + 7'h01;
                        state_q <= ST_RACK;
                     end
                     else
                     begin
                        SDA_OE_O <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                  begin
                     ack_q <= ~s_sda;
                  end
                  else if (scl_fall)
                  begin
                     if (ack_q)
                     begin
                        sh_q <= mem_rd;
                        SDA_OE_O <= ~mem_rd[7];
                        bit_cnt_q <= 4'h1;
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        // No ack: go quiet until a START or STOP
                        state_q <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT:
               begin
                  SDA_OE_O <= 1'b0;
               end
               default:
               begin
                  // Idle ignores everything but a START
                  SDA_OE_O <= 1'b0;
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// >>> hdl/dmsep_consts.vh
// Constants shared by the dual mode serial memory port
// Contract
// - Data line is open drain only; device pulls low or releases.
// - After reset, transmit-only mode streams bytes on transmit-only clock.
// - First SCL falling edge enters bidirectional mode; only reset returns.
// - First nine transmit-only clocks are initialization with no data.
// - Data line high in first eight clocks starts at 7FH, else 00H.
// - Data line released during the ninth initialization clock.
// - Bytes go out MSB first, then a released ninth bit.
// - Transmit-only stream walks the array, wrapping 7FH to 00H.
// - Bidirectional mode ignores transmit-only clock edges; level enables writes.
// - Start only when idle; SDA change with SCL high is START/STOP.
// - START is SDA falling with SCL high; ignore bus before it.
// - STOP is SDA rising with SCL high; master ends with STOP.
// - Slave address upper nibble 1010, next three ignored, LSB direction.
// - Matching address acknowledged on ninth clock, then read or write.
// - Every byte received during a write is acknowledged.
// - Read sends eight bits, samples ack; continue on ack, else wait.
// - Transmit-only clock high through write transfer; ignored once programming.
// - Byte write is address, byte address, data, each acked, then STOP.
// - No response to the master while programming runs.
// - Page write takes sixteen bytes, bumping only low four address bits.
// - More than sixteen bytes wrap within the page, overwriting.
// - STOP programs all buffered page bytes together in one cycle.
// - Write cycle ends within 5 ms; address not acked meanwhile.
// - Address counter holds last address plus one, wrapping 127 to 0.
`ifndef DMSEP_CONSTS_VH
`define DMSEP_CONSTS_VH

// Initialization of the transmit-only stream
`define DMSEP_INIT_CLKS 4'h9
`define DMSEP_INIT_SAMP 4'h8
`define DMSEP_START_HI 7'h7F
`define DMSEP_START_LO 7'h00

// Byte framing
`define DMSEP_BYTE_BITS 4'h8
`define DMSEP_DEV_CODE 4'hA
`define DMSEP_ADDR_W 7
`define DMSEP_PAGE_SZ 16

// Bidirectional protocol phases
`define DMSEP_PH_SLAVE 2'h0
`define DMSEP_PH_WADDR 2'h1
`define DMSEP_PH_WDATA 2'h2

// Write cycle time: microseconds, clock rate, derived cycles
`define DMSEP_TWR_US 5000
`define DMSEP_CLK_MHZ 40
`define DMSEP_TWR_CYC (`DMSEP_TWR_US * `DMSEP_CLK_MHZ)

`endif

// >>> hdl/dmsep_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module dmsep_sync #(
   parameter W = 3
) (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Raw and synchronised levels
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);

   reg [W-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_q <= {W{1'b1}};
         sync_o <= {W{1'b1}};
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

`default_nettype wire

// >>> tb/dmsep_props.sv
// Checker for the dual mode serial memory port pins
`timescale 1ns/1ps
`default_nettype none

module dmsep_props #(
   parameter [17:0] WR_CYCLES = 18'h3_0D40
) (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic ARST_N_I,
   // Pins and status
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_O,
   input wire logic TRANSMIT_ONLY_CLOCK_I,
   input wire logic BIDIRECTIONAL_MODE_O,
   input wire logic BUSY_O
);
   logic [17:0] busy_cnt_q;
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!ARST_N_I);
   // Busy length counter; a stuck busy shows up as a runaway count
   always_ff @(posedge CLOCK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         busy_cnt_q <= 18'h0_0000;
      else
         busy_cnt_q <= BUSY_O ? busy_cnt_q + 18'h0_0001 : 18'h0_0000;
   end
   // Pin and mode relations
   a_drain_only: assert property (SDA_OE_O |-> !SDA_O)
      else $error("data line driven high");
   a_mode_sticky: assert property (
      BIDIRECTIONAL_MODE_O |=> BIDIRECTIONAL_MODE_O)
      else $error("mode left bidirectional");
   a_fall_switch: assert property (
      $fell(SCL_I) |-> ##[1:5] BIDIRECTIONAL_MODE_O)
      else $error("bus clock fall did not switch mode");
   a_mode_cause: assert property ($rose(BIDIRECTIONAL_MODE_O) |->
      !$past(SCL_I, 2) || !$past(SCL_I, 3) ||
      !$past(SCL_I, 4) || !$past(SCL_I, 5))
      else $error("mode switched without bus clock fall");
   a_tx_cause: assert property (
      !BIDIRECTIONAL_MODE_O && SCL_I && $changed(SDA_OE_O) |->
      $past(TRANSMIT_ONLY_CLOCK_I, 3) || $past(TRANSMIT_ONLY_CLOCK_I, 4))
      else $error("stream output moved without its clock");
   a_bidir_cause: assert property (
      BIDIRECTIONAL_MODE_O && $changed(SDA_OE_O) |-> !SCL_I)
      else $error("data line changed while bus clock high");
   a_busy_quiet: assert property (BUSY_O |-> !SDA_OE_O)
      else $error("device answered during write cycle");
   a_busy_bound: assert property (
      BUSY_O |-> busy_cnt_q <= WR_CYCLES + 18'h0_0002)
      else $error("write cycle too long");
   a_busy_len: assert property ($fell(BUSY_O) |->
      $past(busy_cnt_q) + 18'h0_0002 >= WR_CYCLES)
      else $error("write cycle too short");
   a_busy_stop: assert property ($rose(BUSY_O) |->
      $past(SCL_I) && $past(SDA_I) && BIDIRECTIONAL_MODE_O)
      else $error("write cycle began without stop");
endmodule

bind dmsep_top dmsep_props #(.WR_CYCLES(WR_CYCLES)) props_u (
   .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
   .TRANSMIT_ONLY_CLOCK_I(TRANSMIT_ONLY_CLOCK_I),
   .BIDIRECTIONAL_MODE_O(BIDIRECTIONAL_MODE_O), .BUSY_O(BUSY_O));
`default_nettype wire

// >>> tb/dmsep_host.sv
// Behavioural two-wire master and transmit-only clock source
`timescale 1ns/1ps
`default_nettype none

module dmsep_host (
   // Clock and resolved data line
   input wire logic clk_i,
   input wire logic sda_i,
   // Driven lines; a data value of 1 releases to the pull-up
   output logic scl_o,
   output logic sda_o,
   output logic tclk_o
);
   logic [8:0] res_q;
   int res_n;
   // Idle bus with the bus clock held high
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      tclk_o = 1'b0;
      res_q = 9'h000;
      res_n = 0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Hand a finished unit to the bench monitor
   task automatic put(input logic [8:0] v);
      res_q = v;
      res_n++;
   endtask
   // Data changes only while the bus clock is low
   task automatic xbit(input logic b, output logic v);
      sda_o = b;
      w(4);
      scl_o = 1'b1;
      w(4);
      v = sda_i;
      scl_o = 1'b0;
      w(4);
   endtask
   task automatic sta();
      sda_o = 1'b1;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_o = 1'b0;
      w(4);
      scl_o = 1'b0;
      w(4);
   endtask
   task automatic sp();
      sda_o = 1'b0;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_o = 1'b1;
      w(8);
   endtask
   // Byte out, result is the acknowledge level
   task automatic wb(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--)
         xbit(d[i], a);
      xbit(1'b1, a);
      put({8'h00, a});
   endtask
   task automatic rb(input logic nak);
      logic [7:0] d;
      logic a;
      for (int i = 7; i >= 0; i--)
         xbit(1'b1, d[i]);
      xbit(nak, a);
      put({d, 1'b0});
   endtask
   // Nine transmit-only clocks at 200 ns; clock stands low between frames
   task automatic tf(input logic [8:0] drv);
      logic [8:0] v;
      tclk_o = 1'b0;
      w(4);
      for (int i = 8; i >= 0; i--)
      begin
         sda_o = drv[i];
         tclk_o = 1'b1;
         w(4);
         tclk_o = 1'b0;
         w(3);
         v[i] = sda_i;
         w(1);
      end
      sda_o = 1'b1;
      put(v);
   endtask
   task automatic we(input logic v);
      tclk_o = v;
      w(4);
   endtask
endmodule
`default_nettype wire

// >>> tb/dmsep_top_tb_top.sv
// Self-checking bench for the dual mode serial memory port
`timescale 1ns/1ps
`default_nettype none

module dmsep_top_tb_top;
   localparam logic [17:0] WR_N = 18'h0_0190;
   logic clk, rst_n, scl, hsda, tclk, sda_w;
   logic sda_o, sda_oe, mode, busy;
   logic [7:0] mem [0:127];
   logic [8:0] exp_q [$];
   logic [7:0] d;
   int n_mismatch, checks, cyc;
   // Open drain wire with pull-up
   assign sda_w = hsda & (sda_oe ? sda_o : 1'b1);
   always #12.5 clk = ~clk;
   dmsep_top #(.WR_CYCLES(WR_N)) dut_u (
      .CLOCK_I(clk), .ARST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda_w),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .TRANSMIT_ONLY_CLOCK_I(tclk),
      .BIDIRECTIONAL_MODE_O(mode), .BUSY_O(busy));
   dmsep_host host_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
      .sda_o(hsda), .tclk_o(tclk));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic ex(input logic [8:0] v);
      exp_q.push_back(v);
   endtask
   // Byte that must be acknowledged
   task automatic wr(input logic [7:0] v);
      ex(9'h000);
      host_u.wb(v);
   endtask
   task automatic idle();
      for (int i = 0; i < 800 && busy === 1'b1; i++)
         @(posedge clk);
      #1;
      chk({8'h00, busy}, 9'h000);
   endtask
   // Array is kept across reset, as across power cycles
   task automatic rst();
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
   endtask
   // Oldest note against each finished unit
   always @(host_u.res_n)
   begin
      if (exp_q.size() > 0)
         chk(host_u.res_q, exp_q.pop_front());
      else
         chk(host_u.res_q, 9'hx);
   end
   // Hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      void'($urandom(69137));
      rst();
      ex(9'h1FF);
      host_u.tf(9'h1FF);
      chk({8'h00, mode}, 9'h000);
      // First bus clock fall switches mode; its START came too early
      host_u.sta();
      ex(9'h001);
      host_u.wb(8'hA0);
      host_u.sp();
      chk({8'h00, mode}, 9'h001);
      // Foreign device code is ignored
      host_u.sta();
      ex(9'h001);
      host_u.wb({4'h5, 3'($urandom), 1'b0});
      host_u.sp();
      ex(9'h1FF);
      host_u.tf(9'h1FF);
      host_u.we(1'b1);
      // Twenty bytes from 7C wrap inside the page
      host_u.sta();
      wr({4'hA, 3'($urandom), 1'b0});
      wr(8'h7C);
      for (int i = 0; i < 20; i++)
      begin
         d = 8'($urandom);
         mem[{3'h7, 4'(12 + i)}] = d;
         wr(d);
      end
      host_u.sp();
      chk({8'h00, busy}, 9'h001);
      // Enable dropped mid-cycle must not stop programming
      host_u.we(1'b0);
      host_u.sta();
      ex(9'h001);
      host_u.wb(8'hA0);
      host_u.sp();
      idle();
      host_u.we(1'b1);
      host_u.sta();
      wr(8'hA0);
      wr(8'h00);
      for (int i = 0; i < 2; i++)
      begin
         d = 8'($urandom);
         mem[i] = d;
         wr(d);
      end
      host_u.sp();
      idle();
      // Write enable low: acked but never programmed
      host_u.we(1'b0);
      host_u.sta();
      wr(8'hA0);
      wr(8'h70);
      wr(~mem[7'h70]);
      host_u.sp();
      chk({8'h00, busy}, 9'h000);
      host_u.we(1'b1);
      // Selective read through the top of the array
      host_u.sta();
      wr(8'hA0);
      wr(8'h70);
      host_u.sta();
      wr(8'hA1);
      for (int i = 0; i < 17; i++)
      begin
         ex({mem[7'(8'h70 + i)], 1'b0});
         host_u.rb(i == 16);
      end
      host_u.sp();
      host_u.sta();
      wr(8'hA1);
      ex({mem[7'h01], 1'b0});
      host_u.rb(1'b1);
      host_u.sp();
      // Released line during initialization starts the stream at 7F
      rst();
      ex(9'h1FF);
      host_u.tf(9'h1FF);
      ex({mem[7'h7F], 1'b1});
      host_u.tf(9'h1FF);
      ex({mem[7'h00], 1'b1});
      host_u.tf(9'h1FF);
      // Low line during initialization starts the stream at 00
      rst();
      ex(9'h001);
      host_u.tf(9'h001);
      ex({mem[7'h00], 1'b1});
      host_u.tf(9'h1FF);
      final_report();
   end
endmodule
`default_nettype wire
